// *** src/segment_sequence_table_loader.sv ***
`timescale 1ns/1ps
`include "table_loader_regs.svh"
module segment_sequence_table_loader #(
   parameter int CHANNELS    = 4,
   parameter int SEG_DEPTH   = `TL_SEG_MAX_ENTRIES,
   parameter int SEQ_DEPTH   = `TL_SEQ_MAX_ENTRIES,
   parameter int ADDR_W      = 14,
   parameter int CH_W        = 2
) (
   input  wire logic                             i_clk_sys,
   input  wire logic                             i_rst,
   input  wire logic [7:0]                       i_bus_data,
   input  wire logic                             i_bus_valid,
   input  wire logic                             i_bus_eoi,
   input  wire table_loader_pkg::table_kind_type i_table_kind,
   input  wire logic [CH_W-1:0]                  i_channel_select_command,
   input  wire logic                             i_sync_on_loop_complete,
   input  wire logic                             i_mixed_advance,
   input  wire logic                             i_rd_table,
   input  wire logic [ADDR_W-1:0]                i_rd_addr,
   output logic                                  o_busy,
   output logic                                  o_header_error,
   output logic                                  o_load_done,
   output logic      [ADDR_W:0]                  o_entry_count,
   output logic      [63:0]                      o_rd_entry,
   output logic      [15:0]                      o_rd_segment,
   output logic      [23:0]                      o_rd_repeat,
   output logic                                  o_rd_wait_trigger,
   output logic                                  o_rd_sync_mark
);
   import table_loader_pkg::*;

   // per-channel table storage
   logic [31:0] seg_mem [CHANNELS*SEG_DEPTH];
   logic [63:0] seq_mem [CHANNELS*SEQ_DEPTH];

   load_state_type state_reg;
   load_state_type state_next;
   logic [3:0]        ndig_reg;
   logic [31:0]       count_reg;
   logic [31:0]       remain_reg;
   logic [ADDR_W:0]   waddr_reg;
   logic [CH_W-1:0]   ch_reg;
   table_kind_type    kind_reg;
   logic              busy_reg;
   logic              herr_reg;
   logic              done_reg;
   logic [ADDR_W:0]   cnt_out_reg;
   logic [63:0]       rd_reg;
   logic              pay_fire;
   logic              eoi_pend_reg;
   logic [63:0]       entry;
   logic              entry_done;

   // byte classification
   wire is_start  = (i_bus_data == `TL_START_BYTE);
   wire is_digit  = (i_bus_data >= `TL_ASCII_ZERO) && (i_bus_data <= `TL_ASCII_NINE);
   wire [3:0] dig = 4'(i_bus_data - `TL_ASCII_ZERO);
   wire in_pay    = (state_reg == ST_PAYLOAD) && i_bus_valid;
   wire last_pay  = in_pay && (i_bus_eoi || remain_reg == 32'h1);
   wire [31:0] count_step = 32'(count_reg * 32'd10 + 32'(dig));

   // flat row of one channel's table; channels sit depth rows apart
   function automatic logic [31:0] table_index(input logic [CH_W-1:0] ch,
                                                input logic [ADDR_W:0]  row,
                                                input int               depth);
      return 32'(ch) * 32'(depth) + 32'(row);
   endfunction : table_index

   // write and read rows; a row past the depth would spill into the next channel
   wire        seg_row_ok = (32'(waddr_reg) < 32'(SEG_DEPTH));
   wire        seq_row_ok = (32'(waddr_reg) < 32'(SEQ_DEPTH));
   wire [31:0] seg_widx   = table_index(ch_reg, waddr_reg, SEG_DEPTH);
   wire [31:0] seq_widx   = table_index(ch_reg, waddr_reg, SEQ_DEPTH);
   wire [31:0] seg_ridx   = table_index(i_channel_select_command, {1'b0, i_rd_addr}, SEG_DEPTH);
   wire [31:0] seq_ridx   = table_index(i_channel_select_command, {1'b0, i_rd_addr}, SEQ_DEPTH);
   wire        seg_rd_ok  = (32'(i_rd_addr) < 32'(SEG_DEPTH));
   wire        seq_rd_ok  = (32'(i_rd_addr) < 32'(SEQ_DEPTH));

   assign pay_fire = in_pay;

   entry_assembler entry_assembler_i (
      .i_clk_sys    (i_clk_sys),
      .i_rst        (i_rst),
      .i_clear      (state_reg == ST_IDLE),
      .i_byte_valid (pay_fire),
      .i_byte       (i_bus_data),
      .i_kind       (kind_reg),
      .o_entry      (entry),
      .o_entry_done (entry_done)
   );

   // header and payload sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:    if (i_bus_valid && is_start) state_next = ST_NDIGITS;
         ST_NDIGITS: if (i_bus_valid) state_next = (is_digit && dig != 4'h0) ? ST_DIGITS : ST_IDLE;
         ST_DIGITS:  if (i_bus_valid) begin
            if (!is_digit) state_next = ST_IDLE;
            else if (ndig_reg == 4'h1) state_next = ST_PAYLOAD;
         end
         ST_PAYLOAD: if (last_pay) state_next = ST_IDLE;
         default:    state_next = ST_IDLE;
      endcase
   end

   // parser registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg  <= ST_IDLE;
         ndig_reg   <= 4'h0;
         count_reg  <= 32'h0;
         remain_reg <= 32'h0;
         ch_reg     <= '0;
         kind_reg   <= TABLE_SEGMENT;
         herr_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         herr_reg  <= i_bus_valid && ((state_reg == ST_IDLE && !is_start)
                      || (state_reg == ST_NDIGITS && !(is_digit && dig != 4'h0))
                      || (state_reg == ST_DIGITS && !is_digit));
         if (state_reg == ST_IDLE && i_bus_valid && is_start) begin
            ch_reg    <= i_channel_select_command;
            kind_reg  <= i_table_kind;
            count_reg <= 32'h0;
         end
         if (state_reg == ST_NDIGITS && i_bus_valid)
            ndig_reg <= dig;
         if (state_reg == ST_DIGITS && i_bus_valid && is_digit) begin
            count_reg <= count_step;
            ndig_reg  <= ndig_reg - 4'h1;
            if (ndig_reg == 4'h1)
               remain_reg <= count_step;
         end
         if (in_pay)
            remain_reg <= remain_reg - 32'h1;
      end
   end

   // entry write, consecutive addresses, count on termination
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         waddr_reg    <= '0;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
         cnt_out_reg  <= '0;
         eoi_pend_reg <= 1'b0;
      end else begin
         busy_reg     <= (state_next != ST_IDLE);
         eoi_pend_reg <= last_pay;
         done_reg     <= eoi_pend_reg;
         if (state_reg == ST_IDLE)
            waddr_reg <= '0;
         else if (entry_done)
            waddr_reg <= waddr_reg + 1'b1;
         if (eoi_pend_reg)
            cnt_out_reg <= waddr_reg + (ADDR_W+1)'(entry_done);
      end
   end

   // table memories, no content check
   always_ff @(posedge i_clk_sys) begin
      if (entry_done && seg_row_ok && kind_reg == TABLE_SEGMENT)
         seg_mem[seg_widx] <= entry[31:0];
      if (entry_done && seq_row_ok && kind_reg == TABLE_SEQUENCE)
         seq_mem[seq_widx] <= entry;
   end

   // readback of selected channel table
   always_ff @(posedge i_clk_sys) begin
      if (i_rst)
         rd_reg <= 64'h0;
      else if (i_rd_table == TABLE_SEQUENCE)
         rd_reg <= seq_rd_ok ? seq_mem[seq_ridx] : 64'h0;
      else
         rd_reg <= seg_rd_ok ? {32'h0, seg_mem[seg_ridx]} : 64'h0;
   end

   // decoded sequence fields
   logic [15:0] rseg_reg;
   logic [23:0] rrep_reg;
   logic        rwait_reg;
   logic        rsync_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rseg_reg  <= 16'h0;
         rrep_reg  <= 24'h0;
         rwait_reg <= 1'b0;
         rsync_reg <= 1'b0;
      end else begin
         rseg_reg  <= rd_reg[`TL_SEQ_SEG_MSB:`TL_SEQ_SEG_LSB];
         rrep_reg  <= rd_reg[`TL_SEQ_REP_MSB:`TL_SEQ_REP_LSB];
         rwait_reg <= i_mixed_advance && rd_reg[`TL_SEQ_MODE_LSB];
         rsync_reg <= !i_sync_on_loop_complete && rd_reg[`TL_SEQ_SYNC_BIT];
      end
   end

   assign o_busy            = busy_reg;
   assign o_header_error    = herr_reg;
   assign o_load_done       = done_reg;
   assign o_entry_count     = cnt_out_reg;
   assign o_rd_entry        = rd_reg;
   assign o_rd_segment      = rseg_reg;
   assign o_rd_repeat       = rrep_reg;
   assign o_rd_wait_trigger = rwait_reg;
   assign o_rd_sync_mark    = rsync_reg;
endmodule : segment_sequence_table_loader

// *** src/table_loader_regs.svh ***
`ifndef TABLE_LOADER_REGS_SVH
`define TABLE_LOADER_REGS_SVH
// header start byte and ascii digit range
`define TL_START_BYTE       8'h23
`define TL_ASCII_ZERO       8'h30
`define TL_ASCII_NINE       8'h39
// bytes per table entry
`define TL_SEG_ENTRY_BYTES  4'h4
`define TL_SEQ_ENTRY_BYTES  4'h8
// sequence entry field positions (lsb first)
`define TL_SEQ_SEG_LSB      0
`define TL_SEQ_SEG_MSB      15
`define TL_SEQ_REP_LSB      16
`define TL_SEQ_REP_MSB      39
`define TL_SEQ_MODE_LSB     40
`define TL_SEQ_SYNC_BIT     48
// documented table limits
`define TL_SEG_MAX_ENTRIES  16384
`define TL_SEQ_MAX_ENTRIES  4096
`define TL_MAX_SEGMENTS     10000
`endif

// *** src/table_loader_pkg.sv ***
package table_loader_pkg;
   // which table a block is aimed at
   typedef enum logic [0:0] {
      TABLE_SEGMENT  = 1'b0,
      TABLE_SEQUENCE = 1'b1
   } table_kind_type;
   // byte parser states, gray along start -> count -> digits -> payload
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_NDIGITS = 2'b01,
      ST_DIGITS  = 2'b11,
      ST_PAYLOAD = 2'b10
   } load_state_type;
endpackage : table_loader_pkg

// *** src/entry_assembler.sv ***
`timescale 1ns/1ps
`include "table_loader_regs.svh"
// gathers payload bytes into one entry, least significant byte first
module entry_assembler (
   input  wire logic                             i_clk_sys,
   input  wire logic                             i_rst,
   input  wire logic                             i_clear,
   input  wire logic                             i_byte_valid,
   input  wire logic [7:0]                       i_byte,
   input  wire table_loader_pkg::table_kind_type i_kind,
   output logic      [63:0]                      o_entry,
   output logic                                  o_entry_done
);
   import table_loader_pkg::*;

   logic [63:0] shift_reg;
   logic [63:0] shift_next;
   logic [3:0]  idx_reg;
   logic [3:0]  idx_next;
   logic        done_reg;
   wire  [3:0]  entry_len;
   wire         last_byte;

   // entry length by table type
   assign entry_len  = (i_kind == TABLE_SEQUENCE) ? `TL_SEQ_ENTRY_BYTES
                                                  : `TL_SEG_ENTRY_BYTES;
   assign last_byte  = (idx_reg == entry_len - 4'h1);
   // every byte value is data; lsb first
   assign shift_next = (idx_reg == 4'h0) ? {56'h0, i_byte}
                                         : (shift_reg | ({56'h0, i_byte} << {idx_reg, 3'b000}));
   assign idx_next   = last_byte ? 4'h0 : idx_reg + 4'h1;

   // byte index and accumulator
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_clear) begin
         shift_reg <= 64'h0;
         idx_reg   <= 4'h0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= i_byte_valid && last_byte;
         if (i_byte_valid) begin
            shift_reg <= shift_next;
            idx_reg   <= idx_next;
         end
      end
   end

   assign o_entry      = shift_reg;
   assign o_entry_done = done_reg;
endmodule : entry_assembler

// *** sim/segment_sequence_table_loader_properties.sv ***
`timescale 1ns/1ps
// port-level checks of the table loader
module loader_checker #(parameter int ADDR_W = 14) (
   input wire logic            i_clk_sys, i_rst, i_bus_valid, i_bus_eoi,
   input wire logic            i_sync_on_loop_complete, i_mixed_advance,
   input wire logic [7:0]      i_bus_data,
   input wire logic            o_busy, o_header_error, o_load_done,
   input wire logic            o_rd_wait_trigger, o_rd_sync_mark,
   input wire logic [ADDR_W:0] o_entry_count,
   input wire logic [63:0]     o_rd_entry,
   input wire logic [15:0]     o_rd_segment,
   input wire logic [23:0]     o_rd_repeat
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // a byte seen while no block is open
   wire logic idle_byte = i_bus_valid && !o_busy;
   property p_start; idle_byte && i_bus_data == 8'h23 |=> o_busy && !o_header_error; endproperty
   a_start: assert property (p_start) else $error("start byte not taken");
   property p_bad; idle_byte && i_bus_data != 8'h23 |=> o_header_error && !o_busy; endproperty
   a_bad: assert property (p_bad) else $error("stray byte not refused");
   property p_end; o_busy && i_bus_valid && i_bus_eoi |-> ##2 o_load_done; endproperty
   a_end: assert property (p_end) else $error("eoi did not end block");
   property p_done; o_load_done |-> $past(i_bus_valid, 2) && !o_header_error; endproperty
   a_done: assert property (p_done) else $error("done without last byte");
   property p_count; !o_load_done |-> $stable(o_entry_count); endproperty
   a_count: assert property (p_count) else $error("count moved off block end");
   // unwritten table rows read back unknown, so the decode is held to case equality
   property p_seg; o_rd_segment === $past(o_rd_entry[15:0]); endproperty
   a_seg: assert property (p_seg) else $error("segment field wrong");
   property p_rep; o_rd_repeat === $past(o_rd_entry[39:16]); endproperty
   a_rep: assert property (p_rep) else $error("repeat field wrong");
   property p_wait;
      $stable(i_mixed_advance) |->
         o_rd_wait_trigger === ($past(o_rd_entry[40]) && i_mixed_advance);
   endproperty
   a_wait: assert property (p_wait) else $error("advance flag wrong");
   property p_sync; $stable(i_sync_on_loop_complete) |->
      o_rd_sync_mark === ($past(o_rd_entry[48]) && !i_sync_on_loop_complete); endproperty
   a_sync: assert property (p_sync) else $error("sync mark wrong");
   c_load: cover property (o_load_done);
   c_err: cover property (o_header_error);
   c_wait: cover property (o_rd_wait_trigger);
endmodule : loader_checker
bind segment_sequence_table_loader loader_checker #(.ADDR_W(ADDR_W)) loader_checker_i (
   .i_clk_sys, .i_rst, .i_bus_valid, .i_bus_eoi, .i_sync_on_loop_complete,
   .i_mixed_advance, .i_bus_data, .o_busy, .o_header_error, .o_load_done,
   .o_rd_wait_trigger, .o_rd_sync_mark, .o_entry_count, .o_rd_entry,
   .o_rd_segment, .o_rd_repeat);

// *** sim/host_byte_sender.sv ***
`timescale 1ns/1ps
// host side of the byte bus: header, payload, back-to-back bytes
module host_byte_sender (
   input  wire logic i_clk_sys,
   output logic [7:0] o_bus_data,
   output logic       o_bus_valid,
   output logic       o_bus_eoi
);
   initial begin
      o_bus_data = 8'h5a;
      o_bus_valid = 1'b0;
      o_bus_eoi = 1'b0;
   end
   // launch one byte at the falling edge, valid stays up for the next call
   task send_byte(input logic [7:0] b, input logic last);
      @(negedge i_clk_sys);
      o_bus_data = b;
      o_bus_valid = 1'b1;
      o_bus_eoi = last;
   endtask : send_byte
   // release the bus; data flips so a stale byte is never mistaken
   task idle;
      @(negedge i_clk_sys);
      o_bus_valid = 1'b0;
      o_bus_eoi = 1'b0;
      o_bus_data = ~o_bus_data;
   endtask : idle
   // start byte, digit count, then decimal byte count
   task send_header(input int n);
      send_byte(8'h23, 1'b0);
      if (n > 9) begin
         send_byte(8'h32, 1'b0);
         send_byte(8'h30 + 8'(n / 10), 1'b0);
      end else send_byte(8'h31, 1'b0);
      send_byte(8'h30 + 8'(n % 10), 1'b0);
   endtask : send_header
   // one entry, least significant byte first
   task send_entry(input logic [63:0] v, input int nb, input logic last);
      for (int j = 0; j < nb; j++) send_byte(v[8*j+:8], last && j == nb - 1);
   endtask : send_entry
endmodule : host_byte_sender

// *** sim/segment_sequence_table_loader_test.sv ***
`timescale 1ns/1ps
module segment_sequence_table_loader_test;
   import table_loader_pkg::*;
   logic i_clk_sys, i_rst, i_sync_on_loop_complete, i_mixed_advance, i_rd_table;
   logic bus_valid, bus_eoi, o_busy, o_header_error, o_load_done;
   logic o_rd_wait_trigger, o_rd_sync_mark;
   table_kind_type i_table_kind;
   logic [1:0]  i_channel_select_command;
   logic [13:0] i_rd_addr;
   logic [7:0]  bus_data;
   logic [14:0] o_entry_count;
   logic [63:0] o_rd_entry;
   logic [15:0] o_rd_segment;
   logic [23:0] o_rd_repeat;
   int n_errors = 0, num_checks = 0, cycles = 0;
   // sizes stay under one mega-point; bytes 0a, 0d and above 7f are data
   logic [63:0] seg_v [3] = '{64'h000d_ff81, 64'h0000_0a0d, 64'h0001_0a80};
   logic [63:0] seq_v [2] = '{64'h0000_0101_0000_3007, 64'h0001_00fe_0d0a_0005};
   host_byte_sender host_byte_sender_i (.i_clk_sys, .o_bus_data(bus_data),
      .o_bus_valid(bus_valid), .o_bus_eoi(bus_eoi));
   segment_sequence_table_loader #(.SEG_DEPTH(64), .SEQ_DEPTH(64))
      segment_sequence_table_loader_i (.i_clk_sys, .i_rst, .i_bus_data(bus_data),
      .i_bus_valid(bus_valid), .i_bus_eoi(bus_eoi), .i_table_kind,
      .i_channel_select_command, .i_sync_on_loop_complete, .i_mixed_advance,
      .i_rd_table, .i_rd_addr, .o_busy, .o_header_error, .o_load_done, .o_entry_count,
      .o_rd_entry, .o_rd_segment, .o_rd_repeat, .o_rd_wait_trigger, .o_rd_sync_mark);
   // 40 MHz clock
   initial begin
      i_clk_sys = 0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   // hang guard
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // entry one edge after the address, decoded fields one edge later
   task read(input logic tbl, input logic [1:0] ch, input logic [13:0] a);
      @(negedge i_clk_sys);
      i_rd_table = tbl;
      i_channel_select_command = ch;
      i_rd_addr = a;
      repeat (2) @(negedge i_clk_sys);
   endtask : read
   task wait_done(input int cnt);
      host_byte_sender_i.idle();
      for (int i = 0; i < 6 && o_load_done !== 1'b1; i++) @(negedge i_clk_sys);
      check(o_load_done, 1);
      check(o_entry_count, cnt);
   endtask : wait_done
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      i_rst = 1;
      {i_sync_on_loop_complete, i_rd_table, i_rd_addr} = '0;
      i_mixed_advance = 1;
      i_table_kind = TABLE_SEGMENT;
      i_channel_select_command = 1;
      repeat (4) @(negedge i_clk_sys);
      i_rst = 0;
      // stray byte, then a bad digit count
      host_byte_sender_i.send_byte(8'h41, 0);
      host_byte_sender_i.idle();
      check(o_header_error, 1);
      host_byte_sender_i.send_byte(8'h23, 0);
      host_byte_sender_i.send_byte(8'h3a, 0);
      host_byte_sender_i.idle();
      check({o_header_error, o_busy}, 2'b10);
      // three segments into channel 1
      host_byte_sender_i.send_header(12);
      for (int k = 0; k < 3; k++) host_byte_sender_i.send_entry(seg_v[k], 4, k == 2);
      wait_done(3);
      for (int k = 0; k < 3; k++) begin
         read(0, 1, 14'(k));
         check(o_rd_entry, {32'h0, seg_v[k][31:0]});
      end
      // two steps into channel 2
      i_table_kind = TABLE_SEQUENCE;
      i_channel_select_command = 2;
      host_byte_sender_i.send_header(16);
      for (int k = 0; k < 2; k++) host_byte_sender_i.send_entry(seq_v[k], 8, k == 1);
      wait_done(2);
      for (int k = 0; k < 2; k++) begin
         read(1, 2, 14'(k));
         check(o_rd_entry, seq_v[k]);
         check(o_rd_segment, seq_v[k][15:0]);
         check(o_rd_repeat, seq_v[k][39:16]);
         check({o_rd_wait_trigger, o_rd_sync_mark}, {seq_v[k][40], seq_v[k][48]});
      end
      // loop-complete sync type and plain advance hide both flags
      i_sync_on_loop_complete = 1;
      i_mixed_advance = 0;
      read(1, 2, 1);
      check(o_rd_sync_mark, 0);
      read(1, 2, 0);
      check(o_rd_wait_trigger, 0);
      // trailing odd byte on channel 3 is dropped, channel 1 untouched
      i_table_kind = TABLE_SEGMENT;
      i_channel_select_command = 3;
      host_byte_sender_i.send_header(5);
      host_byte_sender_i.send_entry(64'h0000_00c3, 4, 0);
      host_byte_sender_i.send_byte(8'h99, 1);
      wait_done(1);
      read(0, 3, 0);
      check(o_rd_entry[31:0], 32'h0000_00c3);
      read(0, 1, 0);
      check(o_rd_entry[31:0], seg_v[0][31:0]);
      tally_and_finish();
   end
endmodule : segment_sequence_table_loader_test
